// ### bench/cbt_bit_timing_config_sva.sv
// Checker: APB answers, write gating and bit timing relations of the top
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_timing_config_sva #(
  parameter int ADDR_W = cbt_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic oscClockTick,
  input wire logic rxPin,
  input wire logic quantumPulse,
  input wire logic bitStartPulse,
  input wire logic samplePulse,
  input wire logic receivedBit,
  input wire logic initActive
);
  logic [7:0] shadow0Reg;
  logic [7:0] shadow1Reg;
  logic wrCommit;
  logic rdDone;
  assign wrCommit = psel && penable && pready && pwrite && initActive;
  assign rdDone = psel && penable && pready && !pwrite;
  // Shadow of accepted timing writes; a refused write must leave it alone
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shadow0Reg <= 8'h00;
      shadow1Reg <= 8'h00;
    end
    else if (wrCommit && paddr == cbt_pkg::ADDR_BTR0)
      shadow0Reg <= pwdata[7:0];
    else if (wrCommit && paddr == cbt_pkg::ADDR_BTR1)
      shadow1Reg <= pwdata[7:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_ONCE: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  AST_BTR0_READ: assert property (rdDone && paddr == cbt_pkg::ADDR_BTR0 |-> prdata == {24'h000000, shadow0Reg})
    else $error("prescale register readback wrong");
  AST_BTR1_READ: assert property (rdDone && paddr == cbt_pkg::ADDR_BTR1 |-> prdata == {24'h000000, shadow1Reg})
    else $error("segment register readback wrong");
  AST_INIT_HOLD: assert property (initActive [*2] |-> !quantumPulse && !bitStartPulse)
    else $error("timing runs in init mode");
  AST_SAMPLE_ON_QUANTUM: assert property (samplePulse |-> quantumPulse)
    else $error("sample off the quantum grid");
  AST_SAMPLE_NOT_AT_START: assert property (bitStartPulse |-> !samplePulse)
    else $error("sample point at bit start");
  AST_BIT_SAMPLED: assert property ($changed(receivedBit) |-> $past(samplePulse) || $past(samplePulse, 2)
    || $past(initActive))
    else $error("received bit moved without a sample");
endmodule
bind cbt_bit_timing_config cbt_bit_timing_config_sva #(.ADDR_W(ADDR_W)) checker_inst (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .oscClockTick(oscClockTick), .rxPin(rxPin), .quantumPulse(quantumPulse),
  .bitStartPulse(bitStartPulse), .samplePulse(samplePulse), .receivedBit(receivedBit), .initActive(initActive));
`default_nettype wire

// ### bench/cbt_can_node.sv
// Partner model: other bus nodes setting the receive level
`timescale 1ns/100ps
`default_nettype none
module cbt_can_node (
  input wire logic clock,
  input wire logic rst,
  input wire logic driveDominant,
  output logic rxPin
);
  // Wired bus: recessive unless some node pulls it dominant
  always_ff @(posedge clock)
  begin
    if (rst)
      rxPin <= cbt_pkg::RECESSIVE;
    else
      rxPin <= driveDominant ? 1'b0 : cbt_pkg::RECESSIVE;
  end
endmodule
`default_nettype wire

// ### bench/test_can_bit_timing_config.sv
// Testbench of the CAN bit-timing block: registers, init gate, bit timing, sampling
`timescale 1ns/100ps
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    check_count++; \
    if ((exp) !== (got)) \
    begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
module test_can_bit_timing_config;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [31:0] expRd;
    logic expErr;
  } cbt_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic oscClockTick = 1'b0;
  logic driveDominant = 1'b0;
  logic rxPin, pready, pslverr, quantumPulse, bitStartPulse, samplePulse, receivedBit, initActive;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int check_count = 0;
  int oscDiv = 0;
  int quanta = 0;
  int span;
  cbt_row_t rows [10];
  cbt_bit_timing_config DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscClockTick(oscClockTick), .rxPin(rxPin), .quantumPulse(quantumPulse), .bitStartPulse(bitStartPulse),
    .samplePulse(samplePulse), .receivedBit(receivedBit), .initActive(initActive));
  cbt_can_node partner (.clock(clock), .rst(rst), .driveDominant(driveDominant), .rxPin(rxPin));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  // Oscillator strobe every fourth cycle; quantum counter for the bit checks
  always @(posedge clock)
  begin
    oscDiv <= (oscDiv + 1) % 4;
    oscClockTick <= (oscDiv == 3);
    if (quantumPulse === 1'b1)
      quanta <= quanta + 1;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, data};
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      fails++;
  endtask
  // Cycles to the next bit start (0) or sample strobe (1), bounded
  task automatic waitPulse(input int which, output int cycles);
    cycles = 0;
    do
    begin
      @(posedge clock);
      cycles++;
    end
    while (!((which == 0 && bitStartPulse === 1'b1) || (which == 1 && samplePulse === 1'b1)) && cycles < 500);
    if (cycles >= 500)
      fails++;
  endtask
  // Enter init, load both timing registers, leave with the chosen source
  task automatic configure(input logic [7:0] btr0, input logic [7:0] btr1, input logic sel);
    apb(1'b1, cbt_pkg::ADDR_CTRL, {6'h00, sel, 1'b1});
    span = 0;
    while (initActive !== 1'b1 && span < 3000)
    begin
      @(posedge clock);
      span++;
    end
    if (span >= 3000)
      fails++;
    apb(1'b1, cbt_pkg::ADDR_BTR0, btr0);
    apb(1'b1, cbt_pkg::ADDR_BTR1, btr1);
    apb(1'b1, cbt_pkg::ADDR_CTRL, {6'h00, sel, 1'b0});
  endtask
  // Bit length, quanta per bit and sample offset; the first bits settle
  task automatic measure(input int expBit, input int expSample);
    int a;
    int q;
    waitPulse(0, a);
    waitPulse(0, a);
    q = quanta;
    waitPulse(0, a);
    `CHK("bit cycles", expBit, a)
    `CHK("quanta per bit", 8, quanta - q)
    waitPulse(1, a);
    `CHK("sample offset", expSample, a)
  endtask
  // Dominant stream with one recessive quantum centred on the sample point
  task automatic glitch(input logic triple, input logic expBit);
    int c;
    configure(8'h03, {triple, 7'h23}, 1'b1);
    driveDominant <= 1'b1;
    waitPulse(1, c);
    waitPulse(1, c);
    repeat (28) @(posedge clock);
    driveDominant <= 1'b0;
    repeat (4) @(posedge clock);
    driveDominant <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("received bit", expBit, receivedBit)
  endtask
  initial
  begin
    rows[0] = '{1'b0, cbt_pkg::ADDR_BTR0, 8'h00, 32'h00000000, 1'b0};
    rows[1] = '{1'b0, cbt_pkg::ADDR_BTR1, 8'h00, 32'h00000000, 1'b0};
    rows[2] = '{1'b0, cbt_pkg::ADDR_CTRL, 8'h00, 32'h00000001, 1'b0};
    rows[3] = '{1'b1, cbt_pkg::ADDR_BTR0, 8'hc5, 32'h00000000, 1'b0};
    rows[4] = '{1'b0, cbt_pkg::ADDR_BTR0, 8'h00, 32'h000000c5, 1'b0};
    rows[5] = '{1'b1, cbt_pkg::ADDR_BTR1, 8'ha7, 32'h00000000, 1'b0};
    rows[6] = '{1'b0, cbt_pkg::ADDR_BTR1, 8'h00, 32'h000000a7, 1'b0};
    rows[7] = '{1'b0, 12'h010, 8'h00, 32'h00000000, 1'b1};
    rows[8] = '{1'b1, 12'h010, 8'h5a, 32'h00000000, 1'b1};
    rows[9] = '{1'b0, cbt_pkg::ADDR_STATUS, 8'h00, 32'h00000003, 1'b0};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    `CHK("init after reset", 1'b1, initActive)
    // Register rows, all taken in init mode
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      `CHK("error flag", rows[i].expErr, err)
      if (!rows[i].wr)
        `CHK("read data", rows[i].expRd, rd)
    end
    // Outside init the timing registers and the source select refuse writes
    apb(1'b1, cbt_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clock);
    `CHK("init left", 1'b0, initActive)
    apb(1'b1, cbt_pkg::ADDR_BTR0, 8'h11);
    apb(1'b0, cbt_pkg::ADDR_BTR0, 8'h00);
    `CHK("refused write", 32'h000000c5, rd)
    apb(1'b1, cbt_pkg::ADDR_CTRL, 8'h02);
    apb(1'b0, cbt_pkg::ADDR_CTRL, 8'h00);
    `CHK("refused select", 32'h00000000, rd)
    // Oscillator source, one tick per four cycles: 8 quanta of 4 cycles
    configure(8'h00, 8'h23, cbt_pkg::CLK_SEL_OSC);
    measure(32, 20);
    // Bus clock source, prescale by 2: 8 quanta of 2 cycles
    configure(8'hc1, 8'h23, 1'b1);
    measure(16, 10);
    glitch(1'b0, 1'b1);
    glitch(1'b1, 1'b0);
    close_out();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clock);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire

// ### design/cbt_bit_sampler.sv
// Bus level sampler: single sample or majority of three consecutive quanta
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_sampler (
  input wire logic clock,
  input wire logic rst,
  input wire logic quantumTick,
  input wire logic rxLevel,
  input wire logic samplePoint,
  input wire logic tripleSample,
  output logic bitValue
);

  logic [1:0] history_reg;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Level seen on the two quanta before the current one
  always_ff @(posedge clock)
  begin
    if (rst)
      history_reg <= {2{cbt_pkg::RECESSIVE}};
    else if (quantumTick)
      history_reg <= {history_reg[0], rxLevel};
  end

  // Decide the bit on the sample point quantum
  always_ff @(posedge clock)
  begin
    if (rst)
      bitValue <= cbt_pkg::RECESSIVE;
    else if (quantumTick && samplePoint)
    begin
      if (tripleSample)
        bitValue <= majority3(history_reg[1], history_reg[0], rxLevel);
      else
        bitValue <= rxLevel;
    end
  end

endmodule
`default_nettype wire

// ### design/cbt_bit_timing_config.sv
// Top of the CAN bit-timing block: APB registers, init handshake, bit timing
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_timing_config #(
  parameter int ADDR_W = cbt_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator clock source as a tick strobe in this clock domain; the bus clock source is this clock itself
  input wire logic oscClockTick,
  // Bus side
  input wire logic rxPin,
  // Timing outputs
  output logic quantumPulse,
  output logic bitStartPulse,
  output logic samplePulse,
  output logic receivedBit,
  output logic initActive
);

  // Elaboration check: the map needs the full decode width
  if (ADDR_W < cbt_pkg::ADDR_W)
  begin
    $error("cbt_bit_timing_config: ADDR_W too narrow for the register map");
  end

  cbt_pkg::cbt_btr0_t btr0_reg;
  cbt_pkg::cbt_btr1_t btr1_reg;
  cbt_pkg::cbt_ctrl_t ctrl_reg;
  logic initAck_reg;
  logic resyncSeen_reg;
  cbt_pkg::cbt_seg_t seg_reg;
  cbt_pkg::cbt_seg_t seg_next;
  logic [4:0] remain_reg;
  logic [4:0] remain_next;
  logic [4:0] elapsed_reg;
  logic resyncDone_reg;
  logic prevRx_reg;
  logic canClockTick;
  logic quantumTick;
  logic initMode;
  logic accessWrite;
  logic mapped;
  logic rxEdge;
  logic atSample;
  logic bitEnd;
  logic resyncNow;
  logic [4:0] jumpLen;
  logic [4:0] lengthen;
  logic sampledBit;
  cbt_pkg::cbt_status_t statusView;

  // Smaller of two quanta counts, used only to lengthen segment one on resync
  function automatic logic [4:0] minQuanta(input logic [4:0] a, input logic [4:0] b);
    minQuanta = (a < b) ? a : b;
  endfunction

  // Init mode needs both handshake halves set
  assign initMode = ctrl_reg.initRequest && initAck_reg;

  // Select the CAN clock: oscillator strobe or every bus clock edge
  assign canClockTick = (ctrl_reg.protocolClockSelect == cbt_pkg::CLK_SEL_OSC) ? oscClockTick : 1'b1;

  // Write takes effect on the access edge that also sees pready
  assign accessWrite = psel && penable && pready && pwrite;

  assign mapped = (paddr == cbt_pkg::ADDR_CTRL) || (paddr == cbt_pkg::ADDR_STATUS) ||
                  (paddr == cbt_pkg::ADDR_BTR0) || (paddr == cbt_pkg::ADDR_BTR1);

  assign statusView = '{reserved: '0, resyncSeen: resyncSeen_reg,
                        receivedBit: sampledBit, initAcknowledge: initAck_reg};

  // APB answer: pready in the first cycle of the access phase, data from flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= cbt_pkg::READ_ZERO;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      if (paddr == cbt_pkg::ADDR_CTRL)
        prdata <= {24'h000000, ctrl_reg};
      else if (paddr == cbt_pkg::ADDR_STATUS)
        prdata <= {24'h000000, statusView};
      else if (paddr == cbt_pkg::ADDR_BTR0)
        prdata <= {24'h000000, btr0_reg};
      else if (paddr == cbt_pkg::ADDR_BTR1)
        prdata <= {24'h000000, btr1_reg};
      else
        prdata <= cbt_pkg::READ_ZERO;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Timing registers: writes outside init mode are silently dropped
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      btr0_reg <= cbt_pkg::BTR0_RESET;
      btr1_reg <= cbt_pkg::BTR1_RESET;
    end
    else if (accessWrite && initMode)
    begin
      if (paddr == cbt_pkg::ADDR_BTR0)
        btr0_reg <= pwdata[7:0];
      if (paddr == cbt_pkg::ADDR_BTR1)
        btr1_reg <= pwdata[7:0];
    end
  end

  // Request always writable; clock source only while in init mode
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_reg <= cbt_pkg::CTRL_RESET;
    else if (accessWrite && paddr == cbt_pkg::ADDR_CTRL)
    begin
      ctrl_reg.initRequest <= pwdata[0];
      if (initMode)
        ctrl_reg.protocolClockSelect <= pwdata[1];
    end
  end

  // Acknowledge: entered at a bit boundary so no bit is cut, left at once
  always_ff @(posedge clock)
  begin
    if (rst)
      initAck_reg <= 1'b1;
    else if (!ctrl_reg.initRequest)
      initAck_reg <= 1'b0;
    else if (bitEnd || seg_reg == cbt_pkg::SEG_SYNC)
      initAck_reg <= 1'b1;
  end

  // Output from a flop; lags init mode by one cycle, so poll it before writing
  always_ff @(posedge clock)
  begin
    if (rst)
      initActive <= 1'b1;
    else
      initActive <= initMode;
  end

  cbt_quantum_prescaler #(
    .PRESC_W(6)
  ) u_prescaler (
    .clock(clock),
    .rst(rst),
    .hold(initMode),
    .canClockTick(canClockTick),
    .divisorMinusOne(btr0_reg.quantumPrescaler),
    .quantumTick(quantumTick)
  );

  // Recessive to dominant edge seen between two quanta
  always_ff @(posedge clock)
  begin
    if (rst || initMode)
      prevRx_reg <= cbt_pkg::RECESSIVE;
    else if (quantumTick)
      prevRx_reg <= rxPin;
  end

  assign rxEdge = quantumTick && prevRx_reg && !rxPin;

  // Jump width is field plus one quanta
  assign jumpLen = {3'b000, btr0_reg.resyncJumpWidth} + 5'd1;
  assign atSample = quantumTick && seg_reg == cbt_pkg::SEG_ONE && remain_reg == '0;
  assign resyncNow = rxEdge && !resyncDone_reg && seg_reg != cbt_pkg::SEG_SYNC;
  assign lengthen = minQuanta(elapsed_reg, jumpLen);

  // Segment sequencer: sync quantum, segment one, sample, segment two
  always_comb
  begin
    seg_next = seg_reg;
    remain_next = remain_reg;
    bitEnd = 1'b0;
    case (seg_reg)
      cbt_pkg::SEG_SYNC:
      begin
        seg_next = cbt_pkg::SEG_ONE;
        remain_next = {1'b0, btr1_reg.firstSegmentLen};
      end
      cbt_pkg::SEG_ONE:
      begin
        if (remain_reg == '0 && !resyncNow)
        begin
          seg_next = cbt_pkg::SEG_TWO;
          remain_next = {2'b00, btr1_reg.secondSegmentLen};
        end
        else if (resyncNow)
          remain_next = remain_reg + lengthen - ((remain_reg == '0) ? 5'd0 : 5'd1);
        else
          remain_next = remain_reg - 5'd1;
      end
      cbt_pkg::SEG_TWO:
      begin
        if (resyncNow && (remain_reg + 5'd1) <= jumpLen)
        begin
          // Edge close enough: it becomes the next bit's sync quantum
          seg_next = cbt_pkg::SEG_ONE;
          remain_next = {1'b0, btr1_reg.firstSegmentLen};
          bitEnd = 1'b1;
        end
        else if (resyncNow)
          remain_next = remain_reg - jumpLen;
        else if (remain_reg == '0)
        begin
          seg_next = cbt_pkg::SEG_SYNC;
          bitEnd = 1'b1;
        end
        else
          remain_next = remain_reg - 5'd1;
      end
      default:
      begin
        seg_next = cbt_pkg::SEG_SYNC;
      end
    endcase
  end

  // Advance one quantum per tick; the bit is 1 + seg1 + seg2 quanta long
  always_ff @(posedge clock)
  begin
    if (rst || initMode)
    begin
      seg_reg <= cbt_pkg::SEG_SYNC;
      remain_reg <= '0;
    end
    else if (quantumTick)
    begin
      seg_reg <= seg_next;
      remain_reg <= remain_next;
    end
  end

  // Quanta since bit start, measures phase error of edges in segment one
  always_ff @(posedge clock)
  begin
    if (rst || initMode)
      elapsed_reg <= '0;
    else if (quantumTick)
    begin
      if (seg_next == cbt_pkg::SEG_SYNC || (bitEnd && seg_next == cbt_pkg::SEG_ONE))
        elapsed_reg <= '0;
      else if (elapsed_reg != '1)
        elapsed_reg <= elapsed_reg + 5'd1;
    end
  end

  // One resync per bit keeps noise from walking the sample point
  always_ff @(posedge clock)
  begin
    if (rst || initMode)
      resyncDone_reg <= 1'b0;
    else if (resyncNow)
      resyncDone_reg <= 1'b1;
    else if (quantumTick && bitEnd)
      resyncDone_reg <= 1'b0;
  end

  // Sticky resync indicator, cleared on entry to init mode
  always_ff @(posedge clock)
  begin
    if (rst || initMode)
      resyncSeen_reg <= 1'b0;
    else if (resyncNow)
      resyncSeen_reg <= 1'b1;
  end

  cbt_bit_sampler u_sampler (
    .clock(clock),
    .rst(rst || initMode),
    .quantumTick(quantumTick),
    .rxLevel(rxPin),
    .samplePoint(atSample && !resyncNow),
    .tripleSample(btr1_reg.tripleSampleSelect),
    .bitValue(sampledBit)
  );

  // Registered timing strobes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      quantumPulse <= 1'b0;
      bitStartPulse <= 1'b0;
      samplePulse <= 1'b0;
      receivedBit <= cbt_pkg::RECESSIVE;
    end
    else
    begin
      quantumPulse <= quantumTick;
      bitStartPulse <= quantumTick && bitEnd && !initMode;
      samplePulse <= atSample && !resyncNow && !initMode;
      receivedBit <= sampledBit;
    end
  end

endmodule
`default_nettype wire

// ### design/cbt_quantum_prescaler.sv
// Time quantum generator: divides the CAN clock ticks by prescaler plus one
`timescale 1ns/100ps
`default_nettype none
module cbt_quantum_prescaler #(
  parameter int PRESC_W = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold,
  input wire logic canClockTick,
  input wire logic [PRESC_W-1:0] divisorMinusOne,
  output logic quantumTick
);

  // Elaboration check: a zero-width counter cannot divide
  if (PRESC_W < 1)
  begin
    $error("cbt_quantum_prescaler: PRESC_W must be at least 1");
  end

  logic [PRESC_W-1:0] count_reg;

  // Divide by field value plus one; held in init so the bit restarts clean
  always_ff @(posedge clock)
  begin
    if (rst || hold)
    begin
      count_reg <= '0;
      quantumTick <= 1'b0;
    end
    else if (canClockTick)
    begin
      if (count_reg >= divisorMinusOne)
      begin
        count_reg <= '0;
        quantumTick <= 1'b1;
      end
      else
      begin
        count_reg <= count_reg + 1'b1;
        quantumTick <= 1'b0;
      end
    end
    else
    begin
      quantumTick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### shared/cbt_pkg.sv
// Package for the CAN bit-timing configuration block: map, fields, states
//
// Behaviour
// - Timing registers always readable; writes accepted only in initialization mode.
// - Jump width field bits 7:6 gives value plus one quanta, 1 to 4.
// - Prescaler field bits 5:0 divides CAN clock by value plus one.
// - Sampling bit 0: received bit is the single sample at sample point.
// - Sampling bit 1: three samples per bit, majority vote decides.
// - Segment-two field bits 6:4 gives value plus one quanta, 1 to 8.
// - Segment-one field bits 3:0 gives value plus one quanta, 1 to 16.
// - Bit time is prescaler over CAN clock times one plus both segments.
// - Segment lengths fix quanta per bit and the sample point position.
// - Initialization mode active only while request and acknowledge are both set.
// - CAN clock is oscillator clock when select is 0, bus clock when 1.
package cbt_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam int REG_IDX_CTRL = 'h0;
  localparam int REG_IDX_STATUS = 'h1;
  localparam int REG_IDX_BTR0 = 'h2;
  localparam int REG_IDX_BTR1 = 'h3;
  localparam int BYTES_PER_REG = 4;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(REG_IDX_CTRL * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(REG_IDX_STATUS * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_BTR0 = ADDR_W'(REG_IDX_BTR0 * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_BTR1 = ADDR_W'(REG_IDX_BTR1 * BYTES_PER_REG);

  // bus_timing_prescale_jump layout
  typedef struct packed {
    logic [1:0] resyncJumpWidth;
    logic [5:0] quantumPrescaler;
  } cbt_btr0_t;

  // bus_timing_segments_sampling layout
  typedef struct packed {
    logic tripleSampleSelect;
    logic [2:0] secondSegmentLen;
    logic [3:0] firstSegmentLen;
  } cbt_btr1_t;

  // Control register: request and clock source
  typedef struct packed {
    logic [5:0] reserved;
    logic protocolClockSelect;
    logic initRequest;
  } cbt_ctrl_t;

  // Status register: handshake and receive state
  typedef struct packed {
    logic [4:0] reserved;
    logic resyncSeen;
    logic receivedBit;
    logic initAcknowledge;
  } cbt_status_t;

  localparam cbt_btr0_t BTR0_RESET = 8'h00;
  localparam cbt_btr1_t BTR1_RESET = 8'h00;
  localparam cbt_ctrl_t CTRL_RESET = 8'h01;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  localparam logic CLK_SEL_OSC = 1'b0;
  localparam logic RECESSIVE = 1'b1;

  typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} cbt_seg_t;

endpackage
